//--- pid_pkg.sv
// shared types and constants for the pci/isa address decode block
package pid_pkg;
  // address boundaries of the memory map
  localparam logic [31:0] PID_K512     = 32'h0008_0000;
  localparam logic [31:0] PID_K640     = 32'h000a_0000;
  localparam logic [31:0] PID_M1       = 32'h0010_0000;
  localparam logic [31:0] PID_M16      = 32'h0100_0000;
  localparam logic [31:0] PID_M128     = 32'h0800_0000;
  localparam logic [31:0] PID_EXT1M    = 32'hfff0_0000;
  localparam logic [31:0] PID_EXT384   = 32'hfff8_0000;
  localparam logic [31:0] PID_RSV_LOW  = 32'h00f0_0000;
  localparam logic [31:0] PID_RSV_TOP  = 32'h00ff_0000;
  // 64K segment tags (address bits 31:16)
  localparam logic [15:0] PID_SEG_E    = 16'h000e;
  localparam logic [15:0] PID_SEG_F    = 16'h000f;
  localparam logic [15:0] PID_SEG_AE   = 16'hfffe;
  localparam logic [15:0] PID_SEG_AF   = 16'hffff;
  // chip-select control field positions
  localparam int PID_CS_WE     = 2;
  localparam int PID_CS_LOWER  = 6;
  localparam int PID_CS_EXT384 = 7;
  localparam int PID_CS_EXT1M  = 9;
  // top-of-memory field positions
  localparam int PID_TOM_HOLE  = 1;
  localparam int PID_TOM_ESEG  = 3;
  localparam int PID_TOM_LSB   = 3;
  localparam int PID_TOM_MSB   = 7;
  // timing: isa clock is core clock divided, unclaimed cycle length
  localparam int PID_ISA_DIV        = 4;
  localparam int PID_ISA_CLKS       = 6;
  localparam int PID_ISA_CYC_CYCLES = PID_ISA_DIV * PID_ISA_CLKS;
  localparam int PID_SUBTR_WAIT     = 3;
  // request carriers
  typedef struct packed {
    logic [31:0] addr;
    logic        mem;
    logic        io;
    logic        cfg;
    logic        write;
    logic        burst;
  } pid_pci_req_t;
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        dma;
  } pid_isa_req_t;
  typedef struct packed {
    logic        subtr_en;
    logic [15:0] cs_ctl;
    logic [7:0]  top_of_memory_cfg;
    logic [31:0] pm12_base;
    logic [31:0] pm12_mask;
    logic [31:0] pm13_base;
    logic [31:0] pm13_mask;
    logic        apic_en;
    logic [19:0] apic_page;
    logic        hole_en;
    logic [31:0] hole_lo;
    logic [31:0] hole_hi;
  } pid_cfg_t;
  typedef enum logic [1:0] {PID_IDLE = 2'b00, PID_RUN = 2'b01, PID_DONE = 2'b11} pid_state_t;
  typedef enum logic [1:0] {
    PID_TERM_NONE = 2'b00, PID_TERM_DONE = 2'b01, PID_TERM_RETRY = 2'b10, PID_TERM_DISC = 2'b11
  } pid_term_t;
  typedef enum logic [2:0] {
    PID_RESP_NONE, PID_RESP_OK, PID_RESP_TIMEOUT, PID_RESP_NODEV,
    PID_RESP_TABORT, PID_RESP_RETRY, PID_RESP_DISC
  } pid_resp_t;
  typedef enum logic [2:0] {
    PID_END_NONE, PID_END_NORMAL, PID_END_TIMEOUT, PID_END_MABORT,
    PID_END_TABORT, PID_END_RETRY, PID_END_DISC
  } pid_end_t;
endpackage

//--- pid_decode.sv
// pci/isa bridge address decode, routing and bios chip select
`timescale 1ns/1ps
`default_nettype none
module pid_decode
  import pid_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire pid_cfg_t     cfg,
  input  wire logic         pci_req_valid,
  input  wire pid_pci_req_t pci_req,
  input  wire logic         pci_other_claim,
  input  wire logic         int_io_hit_pci,
  input  wire logic         int_io_hit_isa,
  input  wire logic         io_pos_hit,
  input  wire logic         isa_req_valid,
  input  wire pid_isa_req_t isa_req,
  input  wire logic         isa_slave_claim_pin,
  input  wire logic [7:0]   isa_data_pin,
  input  wire pid_resp_t    mst_resp,
  output logic              pci_claim_r,
  output logic              pci_claim_subtr_r,
  output logic              pci_fwd_isa_r,
  output logic              pci_int_r,
  output pid_term_t         pci_term_r,
  output logic              isa_to_pci_r,
  output logic              isa_int_r,
  output logic              isa_cyc_busy_r,
  output logic              isa_cyc_done_r,
  output logic              isa_width16_r,
  output logic [7:0]        isa_rd_data_r,
  output logic              bios_chip_select_n,
  output pid_end_t          mst_end_r
);
  localparam int CW      = $clog2(PID_ISA_CYC_CYCLES);
  localparam int CHK_CYC = PID_ISA_CYC_CYCLES;

  // pin synchronisers (first stage read only by second)
  logic       claim_s1_r, claim_s2_r;
  logic [7:0] data_s1_r, data_s2_r;
  // cycle bookkeeping
  pid_state_t      state_r;           // isa cycle sequencer
  logic [CW-1:0]   cyc_cnt_r;         // core clocks within cycle
  logic            cur_write_r;       // direction of running cycle
  logic            cur_cs_r;          // running cycle selects bios
  logic            cur_burst_r;       // initiator wants more data
  logic            subtr_pend_r;      // waiting out other claimers
  logic [1:0]      subtr_cnt_r;       // wait count
  pid_pci_req_t    pend_req_r;        // request held for subtractive path
  logic            pend_cs_r;
  logic            isa_cs_r;          // isa-master bios select
  logic            start_cyc;         // launch an isa cycle

  // pci-side decode terms
  logic [15:0] pseg;
  logic p_top64, p_low, p_alias_e, p_ext384, p_ext1m, p_bios, p_cs;
  logic p_apic, p_pm, p_int, p_fwd, p_subtr, busy;
  // isa-side decode terms
  logic [31:0] ia, tom_top;
  logic [15:0] iseg;
  logic i_pci, i_cs, i_rsv, i_apic, i_hole;

  // two-flop synchronisers for isa pins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      claim_s1_r <= 1'b0;
      claim_s2_r <= 1'b0;
      data_s1_r  <= 8'h00;
      data_s2_r  <= 8'h00;
    end else begin
      claim_s1_r <= isa_slave_claim_pin;
      claim_s2_r <= claim_s1_r;
      data_s1_r  <= isa_data_pin;
      data_s2_r  <= data_s1_r;
    end
  end

  // pci address-phase decode from current inputs; busy from state_r and subtr_pend_r
  always_comb begin
    pseg      = pci_req.addr[31:16];
    p_top64   = (pseg == PID_SEG_F) || (pseg == PID_SEG_AF);
    p_low     = (pseg == PID_SEG_E) && cfg.cs_ctl[PID_CS_LOWER];
    p_alias_e = (pseg == PID_SEG_AE) && cfg.cs_ctl[PID_CS_LOWER];
    p_ext384  = (pci_req.addr >= PID_EXT384) && (pseg < PID_SEG_AE)
                && cfg.cs_ctl[PID_CS_EXT384];
    p_ext1m   = (pci_req.addr >= PID_EXT1M) && (pci_req.addr < PID_EXT384)
                && cfg.cs_ctl[PID_CS_EXT1M];
    p_bios    = pci_req.mem && (p_top64 || p_low || p_alias_e || p_ext384 || p_ext1m);
    // write protect gates only the select, not the forwarding
    p_cs      = p_bios && (!pci_req.write || cfg.cs_ctl[PID_CS_WE]);
    p_apic    = cfg.apic_en && (pci_req.addr[31:12] == cfg.apic_page);
    p_pm      = pci_req.mem && !cfg.subtr_en
                && ((((pci_req.addr ^ cfg.pm12_base) & ~cfg.pm12_mask) == 32'h0000_0000)
                || (((pci_req.addr ^ cfg.pm13_base) & ~cfg.pm13_mask) == 32'h0000_0000));
    p_int     = pci_req.cfg || (pci_req.io && int_io_hit_pci);
    // positive forward is independent of the subtractive bit for bios
    p_fwd     = !p_int && (p_bios || p_apic || p_pm || (pci_req.io && io_pos_hit));
    // subtractive candidates: anything below 16MB nobody else owns
    p_subtr   = cfg.subtr_en && !p_int && !p_fwd && !pci_req.cfg
                && ((pci_req.mem && (pci_req.addr < PID_M16)) || pci_req.io);
    busy      = (state_r != PID_IDLE) || subtr_pend_r;
  end

  // isa/dma master routing toward main memory
  always_comb begin
    ia      = isa_req.addr;
    iseg    = ia[31:16];
    // top of memory in 1MB steps from the programmed field
    tom_top = {6'h00, ({1'b0, cfg.top_of_memory_cfg[PID_TOM_MSB:PID_TOM_LSB]} + 6'h01), 20'h00000};
    i_rsv   = (ia >= PID_RSV_TOP && ia < PID_M16)
              || (cfg.cs_ctl[PID_CS_LOWER] && ia >= PID_RSV_LOW && ia < PID_RSV_TOP);
    i_apic  = cfg.apic_en && (ia[31:12] == cfg.apic_page);
    i_hole  = cfg.hole_en && (ia >= cfg.hole_lo) && (ia < cfg.hole_hi);
    i_cs    = 1'b0;
    if (ia < PID_K512) begin
      i_pci = 1'b1;
    end else if (ia < PID_K640) begin
      i_pci = !cfg.top_of_memory_cfg[PID_TOM_HOLE];
    end else if (iseg == PID_SEG_E) begin
      // lower bios block: isa and selected when enabled
      i_pci = !cfg.cs_ctl[PID_CS_LOWER] && cfg.top_of_memory_cfg[PID_TOM_ESEG];
      i_cs  = cfg.cs_ctl[PID_CS_LOWER];
    end else if (iseg == PID_SEG_F) begin
      // shadowing does not matter, isa wins here unless the apic page matches
      i_pci = 1'b0;
      i_cs  = 1'b1;
    end else if (ia < PID_M1) begin
      i_pci = 1'b0;
    end else begin
      i_pci = (ia < tom_top) && !i_hole && !i_rsv;
    end
    i_pci = i_pci || i_apic;
    i_cs  = i_cs && (!isa_req.write || cfg.cs_ctl[PID_CS_WE]);
  end

  // pci claim, forward and internal flags, registered one edge after address phase
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pci_claim_r   <= 1'b0;
      pci_fwd_isa_r <= 1'b0;
      pci_int_r     <= 1'b0;
    end else begin
      pci_claim_r   <= pci_req_valid && (p_int || p_fwd);
      pci_fwd_isa_r <= pci_req_valid && p_fwd && !busy;
      pci_int_r     <= pci_req_valid && p_int;
    end
  end

  // subtractive claim: wait for other agents, then take what is left
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      subtr_pend_r      <= 1'b0;
      subtr_cnt_r       <= 2'h0;
      pend_req_r        <= '0;
      pend_cs_r         <= 1'b0;
      pci_claim_subtr_r <= 1'b0;
    end else begin
      pci_claim_subtr_r <= 1'b0;
      if (pci_req_valid && p_subtr && !busy) begin
        subtr_pend_r <= 1'b1;
        subtr_cnt_r  <= 2'h0;
        pend_req_r   <= pci_req;
        // e-segment below 1MB is forwarded but never selected on the subtractive path
        pend_cs_r    <= 1'b0;
      end else if (subtr_pend_r) begin
        if (pci_other_claim) begin
          subtr_pend_r <= 1'b0;
        end else if (subtr_cnt_r == 2'(PID_SUBTR_WAIT - 1)) begin
          subtr_pend_r      <= 1'b0;
          pci_claim_subtr_r <= 1'b1;
        end else begin
          subtr_cnt_r <= subtr_cnt_r + 2'h1;
        end
      end
    end
  end

  assign start_cyc = (pci_req_valid && p_fwd && !p_int && !busy)
                     || (subtr_pend_r && !pci_other_claim
                         && subtr_cnt_r == 2'(PID_SUBTR_WAIT - 1));

  // isa cycle sequencer: fixed 8-bit length whether or not a slave claims
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r     <= PID_IDLE;
      cyc_cnt_r   <= '0;
      cur_write_r <= 1'b0;
      cur_cs_r    <= 1'b0;
      cur_burst_r <= 1'b0;
    end else begin
      unique case (state_r)
        PID_IDLE: begin
          if (start_cyc) begin
            state_r   <= PID_RUN;
            cyc_cnt_r <= '0;
            // positive path captures live request, subtractive the held one;
            // a retried request landing on the subtractive launch must not win
            if (!subtr_pend_r) begin
              cur_write_r <= pci_req.write;
              cur_cs_r    <= p_cs;
              cur_burst_r <= pci_req.burst;
            end else begin
              cur_write_r <= pend_req_r.write;
              cur_cs_r    <= pend_cs_r;
              cur_burst_r <= pend_req_r.burst;
            end
          end
        end
        PID_RUN: begin
          if (cyc_cnt_r == CW'(PID_ISA_CYC_CYCLES - 1)) begin
            state_r <= PID_DONE;
          end else begin
            cyc_cnt_r <= cyc_cnt_r + 1'b1;
          end
        end
        PID_DONE: begin
          state_r <= PID_IDLE;
        end
      endcase
    end
  end

  // cycle status and read data; unclaimed reads sample the bus anyway
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      isa_cyc_busy_r <= 1'b0;
      isa_cyc_done_r <= 1'b0;
      isa_width16_r  <= 1'b0;
      isa_rd_data_r  <= 8'h00;
    end else begin
      isa_cyc_busy_r <= (state_r == PID_RUN);
      isa_cyc_done_r <= (state_r == PID_RUN) && (cyc_cnt_r == CW'(PID_ISA_CYC_CYCLES - 1));
      if (state_r == PID_RUN) begin
        isa_width16_r <= claim_s2_r;
      end
      if (state_r == PID_RUN && cyc_cnt_r == CW'(PID_ISA_CYC_CYCLES - 1) && !cur_write_r) begin
        isa_rd_data_r <= data_s2_r;
      end
    end
  end

  // target terminations: retry while busy, disconnect bursts, else done
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pci_term_r <= PID_TERM_NONE;
    end else if (pci_req_valid && (p_fwd || p_subtr) && !p_int && busy) begin
      pci_term_r <= PID_TERM_RETRY;
    end else if (state_r == PID_DONE) begin
      pci_term_r <= cur_burst_r ? PID_TERM_DISC : PID_TERM_DONE;
    end else begin
      pci_term_r <= PID_TERM_NONE;
    end
  end

  // isa/dma master side routing outputs, followed every cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      isa_to_pci_r <= 1'b0;
      isa_int_r    <= 1'b0;
      isa_cs_r     <= 1'b0;
    end else begin
      isa_to_pci_r <= isa_req_valid && !int_io_hit_isa && i_pci;
      isa_int_r    <= isa_req_valid && int_io_hit_isa;
      isa_cs_r     <= isa_req_valid && !i_pci && i_cs;
    end
  end

  // bios chip select, low during a selected forwarded cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bios_chip_select_n <= 1'b1;
    end else begin
      bios_chip_select_n <= !(((state_r == PID_RUN) && cur_cs_r)
                              || (isa_req_valid && !i_pci && i_cs));
    end
  end

  // master-side termination reporting from the pci engine response
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mst_end_r <= PID_END_NONE;
    end else begin
      unique case (mst_resp)
        PID_RESP_OK:      mst_end_r <= PID_END_NORMAL;
        PID_RESP_TIMEOUT: mst_end_r <= PID_END_TIMEOUT;
        PID_RESP_NODEV:   mst_end_r <= PID_END_MABORT;
        PID_RESP_TABORT:  mst_end_r <= PID_END_TABORT;
        PID_RESP_RETRY:   mst_end_r <= PID_END_RETRY;
        PID_RESP_DISC:    mst_end_r <= PID_END_DISC;
        default:          mst_end_r <= PID_END_NONE;
      endcase
    end
  end

  // checks
  chk_isa_int_src: assert property (@(posedge core_clk) disable iff (!rst_n)
    isa_int_r |-> $past(int_io_hit_isa) && $past(isa_req_valid))
    else $error("isa internal claim without register hit");
  chk_cycle_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state_r == PID_RUN) |-> ##CHK_CYC (state_r == PID_DONE))
    else $error("isa cycle length wrong");
  chk_read_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_r == PID_DONE && !cur_write_r) |-> isa_rd_data_r == $past(data_s2_r))
    else $error("unclaimed read data not sampled");
  chk_low_fwd: assert property (@(posedge core_clk) disable iff (!rst_n)
    (isa_req_valid && !int_io_hit_isa && isa_req.addr < PID_K512) |=> isa_to_pci_r)
    else $error("low memory not forwarded");
  chk_hole_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (isa_req_valid && isa_req.addr >= PID_K512 && isa_req.addr < PID_K640
     && cfg.top_of_memory_cfg[PID_TOM_HOLE] && !i_apic) |=> !isa_to_pci_r)
    else $error("512-640K forwarded while disabled");
  chk_top_bios_isa: assert property (@(posedge core_clk) disable iff (!rst_n)
    (isa_req_valid && isa_req.addr[31:16] == PID_SEG_F && !isa_req.write && !i_apic)
    |=> !isa_to_pci_r && !bios_chip_select_n)
    else $error("top bios not kept on isa");
  chk_write_prot: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pci_req_valid && pci_req.write && p_bios && !cfg.cs_ctl[PID_CS_WE] && !busy
     && !isa_req_valid) |=> ##1 bios_chip_select_n[*4])
    else $error("chip select on protected write");
  chk_retry_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pci_req_valid && p_fwd && !p_int && state_r == PID_RUN) |=> pci_term_r == PID_TERM_RETRY)
    else $error("busy forward not retried");
  chk_ext1m_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pci_req_valid && pci_req.mem && pci_req.addr >= PID_EXT1M && pci_req.addr < PID_EXT384
     && !cfg.cs_ctl[PID_CS_EXT1M] && !p_apic && !p_pm) |=> !pci_fwd_isa_r)
    else $error("disabled 1M bios forwarded");
  chk_bios_pos: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pci_req_valid && pci_req.mem && p_top64 && !busy) |=> pci_claim_r && pci_fwd_isa_r)
    else $error("bios not positively decoded");
  chk_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
    (isa_req_valid && isa_req.addr >= PID_RSV_TOP && isa_req.addr < PID_M16 && !i_apic)
    |=> !isa_to_pci_r)
    else $error("reserved isa memory forwarded");
  chk_subtr_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pci_req_valid && pci_req.mem && !pci_req.io && !cfg.subtr_en && !p_bios && !p_pm
     && !p_apic) |=> !pci_fwd_isa_r)
    else $error("memory forwarded outside positive ranges");
endmodule
`default_nettype wire

//--- pid_isa_slave.sv
// behavioural isa slave on the far side of the bridge's isa bus
`timescale 1ns/1ps
`default_nettype none
module pid_isa_slave (
  input  wire logic       core_clk,
  input  wire logic       present,
  input  wire logic       busy,
  input  wire logic [7:0] val,
  output logic            claim_pin,
  output logic [7:0]      data_pin
);
  // slave claims and drives only inside a running cycle
  // pull-ups leave the data lines high when nobody drives them
  always_ff @(posedge core_clk) begin
    claim_pin <= present & busy;
    data_pin  <= (present & busy) ? val : 8'hff;
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the pci/isa address decode block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pid_pkg::*;
  logic         core_clk, rst_n, pci_req_valid, pci_other_claim, int_io_hit_pci, isa_req_valid;
  logic         slv_on, claim_pin, rt, sc, sf, ss, si, scs, sr, sd, w16;
  logic         int_io_hit_isa, io_pos_hit, cf, bst, sx;
  logic         pci_claim_r, pci_claim_subtr_r, pci_fwd_isa_r, pci_int_r, isa_to_pci_r;
  logic         isa_int_r, isa_cyc_busy_r, isa_cyc_done_r, isa_width16_r, bios_chip_select_n;
  logic [7:0]   slv_val, data_pin, rd, isa_rd_data_r;
  logic [50:0]  tbl [13];
  logic [31:0]  a;
  pid_cfg_t     cfg;
  pid_pci_req_t pci_req;
  pid_isa_req_t isa_req;
  pid_resp_t    mst_resp;
  pid_term_t    pci_term_r;
  pid_end_t     mst_end_r;
  int           bad_count, check_count, seed, len, i, nb;
  // clock at 40 mhz
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  pid_decode i_dut (.core_clk, .rst_n, .cfg, .pci_req_valid, .pci_req, .pci_other_claim,
    .int_io_hit_pci, .int_io_hit_isa, .io_pos_hit, .isa_req_valid, .isa_req,
    .isa_slave_claim_pin(claim_pin), .isa_data_pin(data_pin), .mst_resp, .pci_claim_r,
    .pci_claim_subtr_r, .pci_fwd_isa_r, .pci_int_r, .pci_term_r, .isa_to_pci_r, .isa_int_r,
    .isa_cyc_busy_r, .isa_cyc_done_r, .isa_width16_r, .isa_rd_data_r, .bios_chip_select_n,
    .mst_end_r);
  pid_isa_slave i_slv (.core_clk, .present(slv_on), .busy(isa_cyc_busy_r), .val(slv_val),
    .claim_pin, .data_pin);
  task automatic complete_run;
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // isa-side routing expectation; hole left disabled, apic page lies above the addresses tested
  function automatic logic isa_fwd(input logic [31:0] x);
    if (x < PID_K512) return 1'b1;
    if (x < PID_K640) return !cfg.top_of_memory_cfg[PID_TOM_HOLE];
    if (x[31:16] == PID_SEG_E) return !cfg.cs_ctl[PID_CS_LOWER] && cfg.top_of_memory_cfg[PID_TOM_ESEG];
    if (x < PID_M1 || (x >= PID_RSV_TOP && x < PID_M16)) return 1'b0;
    if (x >= PID_RSV_LOW && x < PID_M16 && cfg.cs_ctl[PID_CS_LOWER]) return 1'b0;
    return x < ({27'h0, cfg.top_of_memory_cfg[7:3]} + 32'h1) * PID_M1;
  endfunction
  // bios select for isa reads and unprotected writes
  function automatic logic isa_cs(input logic [31:0] x, input logic w);
    return (x[31:16] == PID_SEG_F || (x[31:16] == PID_SEG_E && cfg.cs_ctl[PID_CS_LOWER]))
      && (!w || cfg.cs_ctl[PID_CS_WE]);
  endfunction
  // one pci address phase, then watch pulses until the isa cycle ends
  task automatic pci(input logic [31:0] x, input logic w, input logic m);
    int t0;
    int k;
    t0 = -1;
    len = 0;
    {sc, sf, ss, si, scs, sr, sd, sx} = '0;
    nb = 0;
    @(posedge core_clk);
    pci_req_valid <= 1'b1;
    pci_req       <= {x, m, !m && !cf, cf, w, bst};
    for (k = 0; k < 80; k++) begin
      @(posedge core_clk);
      pci_req_valid <= rt && k == 3;
      #1;
      sc |= pci_claim_r;
      sf |= pci_fwd_isa_r;
      ss |= pci_claim_subtr_r;
      si |= pci_int_r;
      scs |= !bios_chip_select_n;
      sr |= pci_term_r === PID_TERM_RETRY;
      sd |= pci_term_r === PID_TERM_DONE;
      sx |= pci_term_r === PID_TERM_DISC;
      nb += isa_cyc_busy_r;
      if (t0 < 0 && (pci_fwd_isa_r === 1'b1 || pci_claim_subtr_r === 1'b1)) t0 = k;
      if (isa_cyc_done_r === 1'b1 && len == 0) begin
        len = k - t0;
        rd = isa_rd_data_r;
        w16 = isa_width16_r;
      end
      if ((t0 < 0 && k > 8) || (len > 0 && k > t0 + len + 2)) break;
    end
    if (t0 >= 0 && len == 0) begin
      chk(0, 1);
      complete_run();
    end
  endtask
  initial begin
    {pci_req_valid, pci_other_claim, int_io_hit_pci, isa_req_valid, slv_on, rt} = '0;
    {int_io_hit_isa, io_pos_hit, cf, bst} = '0;
    {cfg, pci_req, isa_req, slv_val} = '0;
    mst_resp = PID_RESP_NONE;
    rst_n = 1'b0;
    seed = 26;
    tbl = '{{32'h000f_0000, 16'h0, 3'b011}, {32'hffff_0000, 16'h0, 3'b011},
      {32'h000e_0000, 16'h40, 3'b011}, {32'h000e_0000, 16'h0, 3'b000},
      {32'hfffe_0000, 16'h40, 3'b011}, {32'hfffe_0000, 16'h0, 3'b000},
      {32'hfff8_0000, 16'h80, 3'b011}, {32'hfff8_0000, 16'h0, 3'b000},
      {32'hfff0_0000, 16'h200, 3'b011}, {32'hfff0_0000, 16'h0, 3'b000},
      {32'h000f_0000, 16'h0, 3'b110}, {32'h000f_0000, 16'h4, 3'b111},
      {32'h000c_0000, 16'h0, 3'b000}};
    repeat (12) @(posedge core_clk);
    chk(bios_chip_select_n, 1);
    rst_n <= 1'b1;
    // positive decode of bios windows, write protect, unclaimed cycles
    for (i = 0; i < 13; i++) begin
      @(posedge core_clk);
      cfg.cs_ctl <= tbl[i][18:3];
      slv_on     <= 1'($random(seed));
      slv_val    <= 8'($random(seed));
      pci(tbl[i][50:19], tbl[i][2], 1'b1);
      chk(sf, tbl[i][1]);
      chk(scs, tbl[i][0]);
      if (tbl[i][1]) begin
        chk(len, PID_ISA_CYC_CYCLES);
        chk(nb, PID_ISA_CYC_CYCLES);
        // read data only moves on reads; writes leave it as it was
        if (!tbl[i][2]) chk(rd, slv_on ? slv_val : 8'hff);
        chk(w16, slv_on);
        chk(sd, 1);
      end
    end
    $display("test bios windows done");
    cfg.subtr_en <= 1'b1;
    pci(32'h000c_0000, 1'b0, 1'b1);
    chk({ss, sc, scs}, 3'b100);
    pci_other_claim <= 1'b1;
    pci(32'h000c_0000, 1'b0, 1'b1);
    chk(ss, 0);
    pci_other_claim <= 1'b0;
    pci(32'h0100_0000, 1'b0, 1'b1);
    chk(ss, 0);
    pci(32'h000f_0000, 1'b0, 1'b1);
    chk({sf, ss}, 2'b10);
    $display("test subtractive done");
    cfg <= '{subtr_en: 1'b0, apic_en: 1'b1, apic_page: 20'hfec00, pm12_base: 32'h00d0_0000,
      pm12_mask: 32'h7fff, pm13_base: 32'h0040_0000, pm13_mask: 32'h3f_ffff, default: '0};
    foreach (tbl[j]) begin
      if (j < 3) begin
        a = j == 0 ? 32'hfec0_0000 : j == 1 ? 32'h00d0_7fff : 32'h007f_ffff;
        pci(a, 1'b1, 1'b1);
        chk(sf, 1);
      end
    end
    int_io_hit_pci <= 1'b1;
    pci(32'h0000_0020, 1'b0, 1'b0);
    chk({si, sf}, 2'b10);
    int_io_hit_pci <= 1'b0;
    rt = 1'b1;
    pci(32'h000f_0000, 1'b0, 1'b1);
    chk(sr, 1);
    rt = 1'b0;
    // bursts are cut after one transfer
    bst = 1'b1;
    pci(32'h000f_0000, 1'b0, 1'b1);
    chk(sx, 1);
    chk(nb, PID_ISA_CYC_CYCLES);
    bst = 1'b0;
    // configuration cycles land on internal registers only
    cf = 1'b1;
    pci(32'h0000_0000, 1'b0, 1'b0);
    chk({si, sc, sf}, 3'b110);
    cf = 1'b0;
    // positive i/o range forwarded with subtractive off
    io_pos_hit <= 1'b1;
    pci(32'h0000_0300, 1'b0, 1'b0);
    chk({sf, scs}, 2'b10);
    io_pos_hit <= 1'b0;
    $display("test pci targets done");
    // isa-side routing: corners first, then random map and config
    for (i = 0; i < 60; i++) begin
      a = i < 10 ? 32'h7ffff * (i + 1) + i : $random(seed) & 32'h01ff_ffff;
      if (i == 1) a = PID_K640 - 32'h1;
      if (i == 2) a = PID_RSV_TOP;
      if (i == 3) a = PID_M1 - 32'h0001_8000; // e segment
      if (i == 4) a = PID_M1 - 32'h0000_8000; // f segment
      @(posedge core_clk);
      cfg.top_of_memory_cfg        <= 8'($random(seed));
      cfg.cs_ctl     <= 16'($random(seed));
      int_io_hit_isa <= i % 6 == 5;
      isa_req_valid <= 1'b1;
      isa_req       <= {a, 1'($random(seed)), 1'($random(seed))};
      repeat (2) @(posedge core_clk);
      #1;
      chk(isa_to_pci_r, isa_fwd(a) && !int_io_hit_isa);
      chk(isa_int_r, int_io_hit_isa);
      chk(!bios_chip_select_n, isa_cs(a, isa_req.write));
    end
    isa_req_valid  <= 1'b0;
    int_io_hit_isa <= 1'b0;
    $display("test isa routing done");
    // termination codes map one to one onto master endings
    for (i = 0; i < 7; i++) begin
      @(posedge core_clk);
      mst_resp <= pid_resp_t'(i);
      repeat (2) @(posedge core_clk);
      #1;
      chk(mst_end_r, i);
    end
    $display("test terminations done");
    complete_run();
  end
endmodule
`default_nettype wire
